// File: hdl/pcg_consts.vh
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH

// Register byte offsets
`define PCG_OFF_RUN_CFG     12'h060
`define PCG_OFF_RUN0        12'h100
`define PCG_OFF_RUN1        12'h104
`define PCG_OFF_SLP0        12'h110
`define PCG_OFF_SLP1        12'h114
`define PCG_OFF_DS0         12'h120
`define PCG_OFF_DS1         12'h124
`define PCG_OFF_INT_STAT    12'h180
`define PCG_OFF_INT_MASK    12'h184
`define PCG_OFF_FAULT_INFO  12'h188

// Gate bit positions, group one
`define PCG_BIT_EXT_PERIPH_IF   30
`define PCG_BIT_AUDIO_SERIAL    28
`define PCG_BIT_COMPARATOR_TWO  26
`define PCG_BIT_COMPARATOR_ONE  25
`define PCG_BIT_COMPARATOR_ZERO 24
`define PCG_BIT_GP_TIMER_THREE  19
`define PCG_BIT_GP_TIMER_ZERO   16
`define PCG_BIT_TWO_WIRE_ONE    14
`define PCG_BIT_TWO_WIRE_ZERO   12
`define PCG_BIT_QUAD_ENC_ONE    9
`define PCG_BIT_QUAD_ENC_ZERO   8
`define PCG_BIT_SYNC_SER_ONE    5
`define PCG_BIT_SYNC_SER_ZERO   4
`define PCG_BIT_ASYNC_SER_TWO   2
`define PCG_BIT_ASYNC_SER_ZERO  0

// Gate bit positions, group zero
`define PCG_BIT_PWM             20
`define PCG_BIT_CONVERTER_ONE   17
`define PCG_BIT_CONVERTER_ZERO  16
`define PCG_BIT_WATCHDOG_ZERO   3
`define PCG_BIT_GRP0_RSVD_ONE   6

// Writable bits of each group
`define PCG_MASK_GRP1       32'h570F_5337
`define PCG_MASK_GRP0       32'h0013_0008
`define PCG_RSVD_ONES_GRP0  32'h0000_0040

// Reset values
`define PCG_RST_RUN1        32'h0000_0000
`define PCG_RST_GRP0        32'h0000_0040
`define PCG_RST_ZERO        32'h0000_0000

// Run clock configuration: automatic gating bit
`define PCG_BIT_AUTO_GATE   27

// Interrupt status bits
`define PCG_IRQ_FAULT       0
`define PCG_IRQ_MODE        1
`define PCG_IRQ_MASK_BITS   32'h0000_0003

// Power mode codes
`define PCG_MODE_RUN        2'h0
`define PCG_MODE_SLEEP      2'h1
`define PCG_MODE_DEEP       2'h2

`endif

// File: hdl/pcg_enable_sel.v
`include "pcg_consts.vh"

module pcg_enable_sel (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        ce,
    input  wire [31:0] run0,
    input  wire [31:0] run1,
    input  wire [31:0] slp0,
    input  wire [31:0] slp1,
    input  wire [31:0] ds0,
    input  wire [31:0] ds1,
    input  wire        sleepReq,
    input  wire        deepSleepReq,
    input  wire        autoGate,
    output reg  [31:0] en0_r,
    output reg  [31:0] en1_r,
    output reg  [1:0]  mode_r
);
    localparam [1:0] MODE_RUN   = `PCG_MODE_RUN;
    localparam [1:0] MODE_SLEEP = `PCG_MODE_SLEEP;
    localparam [1:0] MODE_DEEP  = `PCG_MODE_DEEP;

    reg [1:0]  mode_nxt;
    reg [31:0] en0_nxt;
    reg [31:0] en1_nxt;

    // Low-power registers only count when automatic gating is on
    always @* begin
        if (!autoGate || !(sleepReq || deepSleepReq))
            mode_nxt = MODE_RUN;
        else if (deepSleepReq)
            mode_nxt = MODE_DEEP;
        else
            mode_nxt = MODE_SLEEP;
    end

    always @* begin
        case (mode_r)
            MODE_RUN: begin
                en0_nxt = run0;
                en1_nxt = run1;
            end
            MODE_SLEEP: begin
                en0_nxt = slp0;
                en1_nxt = slp1;
            end
            MODE_DEEP: begin
                en0_nxt = ds0;
                en1_nxt = ds1;
            end
            default: begin
                en0_nxt = run0;
                en1_nxt = run1;
            end
        endcase
    end

    // Enables only move at a clock edge, so no gated pulse is cut short
    always @(posedge clk) begin
        if (sys_rst) begin
            mode_r <= MODE_RUN;
            en0_r  <= `PCG_RST_ZERO;
            en1_r  <= `PCG_RST_ZERO;
        end else if (ce) begin
            mode_r <= mode_nxt;
            en0_r  <= en0_nxt & `PCG_MASK_GRP0;
            en1_r  <= en1_nxt & `PCG_MASK_GRP1;
        end
    end
endmodule // pcg_enable_sel

// File: hdl/pcg_top.v
`include "pcg_consts.vh"

module pcg_top (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_r,
    output reg         pready_r,
    output reg         pslverr_r,
    input  wire        sleepReq,
    input  wire        deepSleepReq,
    input  wire        periphAccess,
    input  wire [5:0]  periphIdx,
    output reg         periphGrant_r,
    output reg         periphFault_r,
    output wire [31:0] clkEnable0,
    output wire [31:0] clkEnable1,
    output reg         irq_r
);
    reg [31:0] run0_r;
    reg [31:0] run1_r;
    reg [31:0] slp0_r;
    reg [31:0] slp1_r;
    reg [31:0] ds0_r;
    reg [31:0] ds1_r;
    reg [31:0] runCfg_r;
    reg [31:0] intStat_r;
    reg [31:0] intMask_r;
    reg [5:0]  faultIdx_r;
    reg [1:0]  modeSeen_r;

    reg [31:0] readData;
    reg        addrHit;
    reg [31:0] intStat_nxt;

    wire [31:0] en0;
    wire [31:0] en1;
    wire [1:0]  mode;
    wire        setupDone;
    wire        busDone;
    wire        busWrite;
    wire        faultNow;
    wire        modeEvent;
    wire [31:0] eventSet;

    // Keeps only the bits that exist in a group
    function [31:0] gateField;
        input [31:0] data;
        input        grpZero;
        begin
            if (grpZero)
                gateField = data & `PCG_MASK_GRP0;
            else
                gateField = data & `PCG_MASK_GRP1;
        end
    endfunction

    // Group zero registers show a fixed one at a reserved position
    function [31:0] readGrp0;
        input [31:0] data;
        begin
            readGrp0 = gateField(data, 1'b1) | `PCG_RSVD_ONES_GRP0;
        end
    endfunction

    // Indices 0..31 are group one bits, 32..63 group zero bits
    function enabledAt;
        input [5:0]  idx;
        input [31:0] e0;
        input [31:0] e1;
        begin
            if (idx[5])
                enabledAt = e0[idx[4:0]];
            else
                enabledAt = e1[idx[4:0]];
        end
    endfunction

    pcg_enable_sel u_sel (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .ce           (ce),
        .run0         (run0_r),
        .run1         (run1_r),
        .slp0         (slp0_r),
        .slp1         (slp1_r),
        .ds0          (ds0_r),
        .ds1          (ds1_r),
        .sleepReq     (sleepReq),
        .deepSleepReq (deepSleepReq),
        .autoGate     (runCfg_r[`PCG_BIT_AUTO_GATE]),
        .en0_r        (en0),
        .en1_r        (en1),
        .mode_r       (mode)
    );

    assign clkEnable0 = en0;
    assign clkEnable1 = en1;

    // One wait state: data is fetched in the first access cycle
    assign setupDone = psel & penable & ~pready_r;
    assign busDone   = psel & penable & pready_r;
    assign busWrite  = busDone & pwrite & ~pslverr_r;

    always @* begin
        readData = 32'h0000_0000;
        addrHit  = 1'b1;
        case (paddr)
            `PCG_OFF_RUN_CFG:
                readData = runCfg_r;
            `PCG_OFF_RUN0:
                readData = readGrp0(run0_r);
            `PCG_OFF_RUN1:
                readData = gateField(run1_r, 1'b0);
            `PCG_OFF_SLP0:
                readData = readGrp0(slp0_r);
            `PCG_OFF_SLP1:
                readData = gateField(slp1_r, 1'b0);
            `PCG_OFF_DS0:
                readData = readGrp0(ds0_r);
            `PCG_OFF_DS1:
                readData = gateField(ds1_r, 1'b0);
            `PCG_OFF_INT_STAT:
                readData = intStat_r;
            `PCG_OFF_INT_MASK:
                readData = intMask_r;
            `PCG_OFF_FAULT_INFO:
                readData = {26'h000_0000, faultIdx_r};
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r  <= setupDone;
            pslverr_r <= setupDone & ~addrHit;
            if (setupDone && !pwrite && addrHit)
                prdata_r <= readData;
            else if (setupDone)
                prdata_r <= 32'h0000_0000;
        end
    end

    // Stored gate bits are masked so reserved positions stay zero
    always @(posedge clk) begin
        if (sys_rst) begin
            run0_r   <= `PCG_RST_ZERO;
            run1_r   <= `PCG_RST_RUN1;
            slp0_r   <= `PCG_RST_ZERO;
            slp1_r   <= `PCG_RST_ZERO;
            ds0_r    <= `PCG_RST_ZERO;
            ds1_r    <= `PCG_RST_ZERO;
            runCfg_r <= `PCG_RST_ZERO;
        end else if (ce && busWrite) begin
            case (paddr)
                `PCG_OFF_RUN_CFG:
                    runCfg_r <= pwdata & (32'h1 << `PCG_BIT_AUTO_GATE);
                `PCG_OFF_RUN0:
                    run0_r <= gateField(pwdata, 1'b1);
                `PCG_OFF_RUN1:
                    run1_r <= gateField(pwdata, 1'b0);
                `PCG_OFF_SLP0:
                    slp0_r <= gateField(pwdata, 1'b1);
                `PCG_OFF_SLP1:
                    slp1_r <= gateField(pwdata, 1'b0);
                `PCG_OFF_DS0:
                    ds0_r <= gateField(pwdata, 1'b1);
                `PCG_OFF_DS1:
                    ds1_r <= gateField(pwdata, 1'b0);
                default: begin
                    run0_r <= run0_r;
                end
            endcase
        end
    end

    // Peripheral-side access check against the enables now in force
    assign faultNow  = periphAccess & ~enabledAt(periphIdx, en0, en1);
    assign modeEvent = (mode != modeSeen_r);

    always @(posedge clk) begin
        if (sys_rst) begin
            periphGrant_r <= 1'b0;
            periphFault_r <= 1'b0;
            faultIdx_r    <= 6'h00;
            modeSeen_r    <= `PCG_MODE_RUN;
        end else if (ce) begin
            periphGrant_r <= periphAccess & ~faultNow;
            periphFault_r <= faultNow;
            modeSeen_r    <= mode;
            if (faultNow)
                faultIdx_r <= periphIdx;
        end
    end

    assign eventSet = {30'h0000_0000, modeEvent, faultNow};

    // Write one to clear; an event in the same cycle keeps its bit set
    always @* begin
        intStat_nxt = intStat_r;
        if (busWrite && paddr == `PCG_OFF_INT_STAT)
            intStat_nxt = intStat_r & ~pwdata;
        intStat_nxt = (intStat_nxt | eventSet) & `PCG_IRQ_MASK_BITS;
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            intStat_r <= 32'h0000_0000;
            intMask_r <= 32'h0000_0000;
            irq_r     <= 1'b0;
        end else if (ce) begin
            intStat_r <= intStat_nxt;
            if (busWrite && paddr == `PCG_OFF_INT_MASK)
                intMask_r <= pwdata & `PCG_IRQ_MASK_BITS;
            irq_r <= |(intStat_nxt & intMask_r);
        end
    end
endmodule // pcg_top

// File: bench/pcg_top_properties.sv
module pcg_top_props (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_r,
    input wire logic        pready_r,
    input wire logic        pslverr_r,
    input wire logic        sleepReq,
    input wire logic        deepSleepReq,
    input wire logic        periphAccess,
    input wire logic [5:0]  periphIdx,
    input wire logic        periphGrant_r,
    input wire logic        periphFault_r,
    input wire logic [31:0] clkEnable0,
    input wire logic [31:0] clkEnable1,
    input wire logic        irq_r
);
    localparam logic [31:0] MASK1 = 32'h570F_5337;
    localparam logic [31:0] MASK0 = 32'h0013_0008;
    logic hitEn;
    logic wrRun;
    assign hitEn = periphIdx[5] ? clkEnable0[periphIdx[4:0]]
                                : clkEnable1[periphIdx[4:0]];
    assign wrRun = psel && pwrite && pready_r && paddr == 12'h104;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_GRANT: assert property (
        periphAccess && ce && hitEn |=> periphGrant_r && !periphFault_r)
        else $error("clocked module refused");
    AST_FAULT: assert property (
        periphAccess && ce && !hitEn |=> periphFault_r && !periphGrant_r)
        else $error("gated module not faulted");
    AST_QUIET: assert property (
        !periphAccess && ce |=> !periphGrant_r && !periphFault_r)
        else $error("answer without access");
    AST_RSV1: assert property ((clkEnable1 & ~MASK1) == 0)
        else $error("absent group one enable");
    AST_RSV0: assert property ((clkEnable0 & ~MASK0) == 0)
        else $error("absent group zero enable");
    AST_ERR: assert property (
        pslverr_r |-> pready_r && prdata_r == 32'h0)
        else $error("bad error response");
    AST_RSTEN: assert property (
        $fell(sys_rst) |-> clkEnable1 == 0 && clkEnable0 == 0 && !irq_r)
        else $error("enables set after reset");
    AST_RUN_EN: assert property (
        wrRun && ce && !sleepReq && !deepSleepReq |=> ##1
        clkEnable1 == ($past(pwdata, 2) & MASK1))
        else $error("run write not applied");
    AST_PULSE: assert property (pready_r |=> !pready_r)
        else $error("ready longer than one cycle");
    COV_GRANT: cover property (periphGrant_r);
    COV_FAULT: cover property (periphFault_r);
    COV_IRQ: cover property ($rose(irq_r));
endmodule // pcg_top_props

bind pcg_top pcg_top_props pcg_top_props_inst (
    .clk, .sys_rst, .ce, .psel, .pwrite, .paddr, .pwdata, .prdata_r,
    .pready_r, .pslverr_r, .sleepReq, .deepSleepReq, .periphAccess,
    .periphIdx, .periphGrant_r, .periphFault_r, .clkEnable0,
    .clkEnable1, .irq_r
);

// File: bench/pcg_periph_model.sv
module pcg_periph_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [5:0] goIdx,
    input  wire logic       grant,
    input  wire logic       fault,
    output logic            periphAccess,
    output logic [5:0]      periphIdx,
    output logic            gotGrant,
    output logic            gotFault
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        periphAccess = 0;
        periphIdx = 6'h00;
        gotGrant = 0;
        gotFault = 0;
    end
    // Idle target index toggles so a stale value is never trusted
    always @(posedge clk) begin
        periphAccess <= go;
        periphIdx <= go ? goIdx : ~periphIdx;
        gotGrant <= go ? 1'b0 : gotGrant | grant;
        gotFault <= go ? 1'b0 : gotFault | fault;
    end
endmodule // pcg_periph_model

// File: bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] MASK1 = 32'h570F_5337;
    localparam logic [31:0] MASK0 = 32'h0013_0008;
    logic        clk, sysRst, ce, psel, penable, pwrite, pready, pslverr;
    logic        sleepReq, deepReq, pAcc, grant, fault, irq;
    logic        go, gotG, gotF, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, en0, en1, rdat;
    logic [5:0]  pIdx, goIdx;
    int          n_fail, total_checks;

    pcg_top pcg_top_inst (.clk(clk), .sys_rst(sysRst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_r(prdata), .pready_r(pready),
        .pslverr_r(pslverr), .sleepReq(sleepReq),
        .deepSleepReq(deepReq), .periphAccess(pAcc), .periphIdx(pIdx),
        .periphGrant_r(grant), .periphFault_r(fault),
        .clkEnable0(en0), .clkEnable1(en1), .irq_r(irq));
    pcg_periph_model pcg_periph_model_inst (.clk(clk), .go(go),
        .goIdx(goIdx), .grant(grant), .fault(fault), .periphAccess(pAcc),
        .periphIdx(pIdx), .gotGrant(gotG), .gotFault(gotF));

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    task summarize;
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Two idle edges at the end let enable and irq updates land
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        rerr = pslverr;
        if (k >= 20) begin
            n_fail++;
            summarize();
        end
        psel <= 0;
        penable <= 0;
        repeat (2) @(posedge clk);
    endtask

    task acc(input logic [5:0] i);
        go <= 1;
        goIdx <= i;
        @(posedge clk);
        go <= 0;
        repeat (4) @(posedge clk);
    endtask

    task sweep(input logic [31:0] m, input logic [5:0] b);
        for (int i = 0; i < 32; i++) begin
            acc(b + 6'(i));
            chk({30'h0, gotF, gotG}, m[i] ? 32'h1 : 32'h2);
        end
    endtask

    task t_reset;
        apb(0, 12'h104, 32'h0);
        chk(rdat, 32'h0);
        chk(en1, 32'h0);
        apb(0, 12'h120, 32'h0);
        chk(rdat, 32'h0000_0040);
        apb(0, 12'h0FC, 32'h0);
        chk({31'h0, rerr}, 32'h1);
    endtask

    task t_run;
        apb(1, 12'h104, 32'hFFFF_FFFF);
        apb(0, 12'h104, 32'h0);
        chk(rdat, MASK1);
        chk(en1, MASK1);
        sweep(MASK1, 6'd0);
    endtask

    task t_grp0;
        apb(1, 12'h120, 32'hFFFF_FFFF);
        apb(0, 12'h120, 32'h0);
        chk(rdat, MASK0 | 32'h40);
        apb(1, 12'h100, 32'hFFFF_FFFF);
        chk(en0, MASK0);
        sweep(MASK0, 6'd32);
    endtask

    task t_irq;
        apb(1, 12'h104, 32'h0);
        apb(1, 12'h180, 32'h3);
        apb(1, 12'h184, 32'h1);
        chk({31'h0, irq}, 32'h0);
        acc(6'd1);
        chk({30'h0, gotF, gotG}, 32'h2);
        chk({31'h0, irq}, 32'h1);
        apb(0, 12'h188, 32'h0);
        chk(rdat, 32'h1);
        apb(0, 12'h180, 32'h0);
        chk(rdat & 32'h1, 32'h1);
        apb(1, 12'h180, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1, 12'h184, 32'h0);
        acc(6'd1);
        chk({31'h0, irq}, 32'h0);
    endtask

    task t_modes;
        apb(1, 12'h104, 32'h1);
        apb(1, 12'h114, 32'h2);
        apb(1, 12'h124, 32'h4);
        sleepReq <= 1;
        repeat (3) @(posedge clk);
        chk(en1, 32'h1);
        apb(1, 12'h060, 32'h0800_0000);
        repeat (2) @(posedge clk);
        chk(en1, 32'h2);
        deepReq <= 1;
        repeat (3) @(posedge clk);
        chk(en1, 32'h4);
        sleepReq <= 0;
        deepReq <= 0;
        repeat (3) @(posedge clk);
        chk(en1, 32'h1);
        // Frozen block must not answer a peripheral access
        ce <= 0;
        acc(6'd1);
        chk({30'h0, gotF, gotG}, 32'h0);
        ce <= 1;
        acc(6'd1);
        chk({30'h0, gotF, gotG}, 32'h2);
    endtask

    initial begin
        {sysRst, ce} = 2'b11;
        {psel, penable, pwrite, sleepReq, deepReq, go} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        goIdx = 6'h00;
        n_fail = 0;
        total_checks = 0;
        repeat (10) @(posedge clk);
        sysRst <= 0;
        t_reset();
        t_run();
        t_grp0();
        t_irq();
        t_modes();
        summarize();
    end
endmodule // testbench
